/* rtl/ptcc_pkg.sv */
// Package for the periodic timer counter control block: offsets, fields, resets, enums.
// Assumes a 32-bit classic Wishbone register bus with one byte register per aligned word.
package ptcc_pkg;

  // Register byte addresses (one aligned word each)
  localparam logic [5:0] OFS_CONTROL_A   = 6'h00;
  localparam logic [5:0] OFS_CONTROL_B   = 6'h04;
  localparam logic [5:0] OFS_COUNT_LOW   = 6'h08;
  localparam logic [5:0] OFS_COUNT_HIGH  = 6'h0C;
  localparam logic [5:0] OFS_CMP_A_LOW   = 6'h10;
  localparam logic [5:0] OFS_CMP_A_HIGH  = 6'h14;
  localparam logic [5:0] OFS_PERIOD_LOW  = 6'h18;
  localparam logic [5:0] OFS_PERIOD_HIGH = 6'h1C;
  localparam logic [5:0] OFS_IRQ_STATUS  = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK    = 6'h24;

  // Field positions in timer_control_a
  localparam int POS_PAUSE  = 7;
  localparam int POS_CLKSEL = 4;
  localparam int POS_ON_OFF = 3;
  // Field positions in timer_control_b
  localparam int POS_MODE   = 6;
  localparam int POS_OUTSEL = 4;
  localparam int POS_OUTCTL = 3;
  localparam int POS_POLAR  = 2;
  localparam int POS_CCLR   = 0;
  // Interrupt status bits
  localparam int POS_IRQ_A  = 0;
  localparam int POS_IRQ_P  = 1;

  // Reset values
  localparam logic [7:0] RST_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_CONTROL_B = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [1:0] RST_IRQ       = 2'h0;
  localparam logic [7:0] CTRL_A_MASK   = 8'hF8;   // Bits 2..0 unimplemented

  // Prescaler divide counts
  localparam int DIV_SYS4  = 4;
  localparam int DIV_H16   = 16;
  localparam int DIV_H64   = 64;

  // Clock select codes
  typedef enum logic [2:0] {
    PTCC_CK_SYS4 = 3'h0,
    PTCC_CK_SYS  = 3'h1,
    PTCC_CK_H16  = 3'h2,
    PTCC_CK_H64  = 3'h3,
    PTCC_CK_SUBA = 3'h4,
    PTCC_CK_SUBB = 3'h5,
    PTCC_CK_RISE = 3'h6,
    PTCC_CK_FALL = 3'h7
  } ptcc_clksel_type;

  // Operating modes
  typedef enum logic [1:0] {
    PTCC_MD_CMP  = 2'h0,
    PTCC_MD_CAP  = 2'h1,
    PTCC_MD_PWM  = 2'h2,
    PTCC_MD_TMR  = 2'h3
  } ptcc_mode_type;

  // Bus access state, one-hot
  typedef enum logic [1:0] {
    PTCC_BS_IDLE = 2'b01,
    PTCC_BS_ACK  = 2'b10
  } ptcc_bus_type;

  // Control byte A as fields
  typedef struct packed {
    logic            pause;
    ptcc_clksel_type clk_sel;
    logic            on_off;
    logic [2:0]      unused;
  } ptcc_ctrl_a_type;

  // Control byte B as fields
  typedef struct packed {
    ptcc_mode_type mode;
    logic [1:0]    out_sel;
    logic          out_ctl;
    logic          polarity;
    logic          capt_src;
    logic          cnt_clr_a;
  } ptcc_ctrl_b_type;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } ptcc_wb_req_type;

endpackage

/* rtl/ptcc_tick_gen.sv */
// Counter tick source: internal prescaled ticks and synchronised external pin edges.
// Assumes high clock and subclock arrive as single-cycle enables on the system clock.
`timescale 1ns/100ps
`default_nettype none
module ptcc_tick_gen
  import ptcc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Source selection
  input  wire ptcc_pkg::ptcc_clksel_type clk_sel_i,
  // Clock sources
  input  wire logic             high_tick_i,
  input  wire logic             sub_tick_i,
  input  wire logic             ext_clk_pin_i,
  // Selected tick
  output logic                  tick_o
);
  import ptcc_pkg::*;

  logic [1:0] sys_div_r;
  logic [5:0] h_div_r;
  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       pin_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running prescalers; no reset on select change keeps it simple
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_div_r <= 2'h0;
    end else begin
      sys_div_r <= sys_div_r + 2'h1;
    end
  end

  // High clock divider counts high clock ticks only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_div_r <= 6'h00;
    end else if (high_tick_i) begin
      h_div_r <= h_div_r + 6'h01;
    end
  end

  // Pin passes two flops before the edge detector reads it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= ext_clk_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Source mux, one pulse per qualifying event
  always_comb begin
    case (clk_sel_i)
      PTCC_CK_SYS4: tick_o = (sys_div_r == 2'(DIV_SYS4 - 1));
      PTCC_CK_SYS:  tick_o = 1'b1;
      PTCC_CK_H16:  tick_o = high_tick_i && (h_div_r[3:0] == 4'(DIV_H16 - 1));
      PTCC_CK_H64:  tick_o = high_tick_i && (h_div_r == 6'(DIV_H64 - 1));
      PTCC_CK_SUBA: tick_o = sub_tick_i;
      PTCC_CK_SUBB: tick_o = sub_tick_i;
      PTCC_CK_RISE: tick_o = pin_s2_r && !pin_s3_r;
      PTCC_CK_FALL: tick_o = !pin_s2_r && pin_s3_r;
      default:      tick_o = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/ptcc_timer.sv */
// Periodic timer counter control: register file, 16-bit counter, comparators, output pin.
// Assumes a classic Wishbone master on the system clock and tick enables for other clocks.
`timescale 1ns/100ps
`default_nettype none

module ptcc_timer
  import ptcc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [5:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  // Clock sources
  input  wire logic         high_tick_i,
  input  wire logic         sub_tick_i,
  input  wire logic         ext_clk_pin_i,
  // Timer outputs
  output logic              timer_out_o,
  output logic              timer_out_oe_o,
  output logic              unit_enable_o,
  output logic              irq_o
);
  import ptcc_pkg::*;

  ptcc_wb_req_type  req;
  ptcc_bus_type     bus_state_r;
  ptcc_ctrl_a_type  ctrl_a_r;
  ptcc_ctrl_b_type  ctrl_b_r;
  logic [15:0]      count_r;
  logic [15:0]      cmp_a_r;
  logic [15:0]      period_r;
  logic [1:0]       irq_status_r;
  logic [1:0]       irq_mask_r;
  logic             on_prev_r;
  logic             pin_level_r;
  logic [31:0]      rd_data;
  logic             tick;
  logic             advance;
  logic             match_a;
  logic             match_p;
  logic             overflow;
  logic             clear_cnt;
  logic             ev_a;
  logic             ev_p;
  logic             on_rise;
  logic             wr_hit;
  logic             rd_stat;
  logic [1:0]       irq_nxt;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

  ////////////////////////////////////////////////////////////////////////////
  // Tick source
  ptcc_tick_gen u_tick (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .clk_sel_i     (ctrl_a_r.clk_sel),
    .high_tick_i   (high_tick_i),
    .sub_tick_i    (sub_tick_i),
    .ext_clk_pin_i (ext_clk_pin_i),
    .tick_o        (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one ack per request, then a dead cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_r <= PTCC_BS_IDLE;
    end else begin
      case (bus_state_r)
        PTCC_BS_IDLE: begin
          if (req.cyc && req.stb) begin
            bus_state_r <= PTCC_BS_ACK;
          end
        end
        PTCC_BS_ACK:  bus_state_r <= PTCC_BS_IDLE;
        default:      bus_state_r <= PTCC_BS_IDLE;
      endcase
    end
  end

  // Write and read-clear strobes fire only in the request's first cycle
  assign wr_hit  = (bus_state_r == PTCC_BS_IDLE) && req.cyc && req.stb && req.we && req.sel[0];
  assign rd_stat = (bus_state_r == PTCC_BS_IDLE) && req.cyc && req.stb && !req.we
                   && (req.adr == OFS_IRQ_STATUS);

  // Read mux; unmapped addresses read zero and still ack
  always_comb begin
    rd_data = 32'h0000_0000;
    case (req.adr)
      OFS_CONTROL_A:   rd_data[7:0] = ctrl_a_r & CTRL_A_MASK;
      OFS_CONTROL_B:   rd_data[7:0] = ctrl_b_r;
      OFS_COUNT_LOW:   rd_data[7:0] = count_r[7:0];
      OFS_COUNT_HIGH:  rd_data[7:0] = count_r[15:8];
      OFS_CMP_A_LOW:   rd_data[7:0] = cmp_a_r[7:0];
      OFS_CMP_A_HIGH:  rd_data[7:0] = cmp_a_r[15:8];
      OFS_PERIOD_LOW:  rd_data[7:0] = period_r[7:0];
      OFS_PERIOD_HIGH: rd_data[7:0] = period_r[15:8];
      OFS_IRQ_STATUS:  rd_data[1:0] = irq_status_r;
      OFS_IRQ_MASK:    rd_data[1:0] = irq_mask_r;
      default:         rd_data = 32'h0000_0000;
    endcase
  end

  // Registered ack, raised by the taking edge itself for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_state_r == PTCC_BS_IDLE) && req.cyc && req.stb;
    end
  end

  // Read data captured at the taking edge; stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control byte A; counter registers have no write path at all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_r <= ptcc_ctrl_a_type'(RST_CONTROL_A);
    end else if (wr_hit && req.adr == OFS_CONTROL_A) begin
      ctrl_a_r <= ptcc_ctrl_a_type'(req.dat[7:0] & CTRL_A_MASK);
    end
  end

  // Control byte B; mode changes are safest while the unit is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_b_r <= ptcc_ctrl_b_type'(RST_CONTROL_B);
    end else if (wr_hit && req.adr == OFS_CONTROL_B) begin
      ctrl_b_r <= ptcc_ctrl_b_type'(req.dat[7:0]);
    end
  end

  // First compare value, byte at a time; no latching between halves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_r <= RST_WORD;
    end else if (wr_hit && req.adr == OFS_CMP_A_LOW) begin
      cmp_a_r[7:0] <= req.dat[7:0];
    end else if (wr_hit && req.adr == OFS_CMP_A_HIGH) begin
      cmp_a_r[15:8] <= req.dat[7:0];
    end
  end

  // Period compare value, byte at a time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_r <= RST_WORD;
    end else if (wr_hit && req.adr == OFS_PERIOD_LOW) begin
      period_r[7:0] <= req.dat[7:0];
    end else if (wr_hit && req.adr == OFS_PERIOD_HIGH) begin
      period_r[15:8] <= req.dat[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter core
  // Rising edge of the on/off bit restarts count, and restarts output in compare mode only
  assign on_rise  = ctrl_a_r.on_off && !on_prev_r;
  assign advance  = tick && ctrl_a_r.on_off && !ctrl_a_r.pause;
  // Full-width compares; period zero means wrap at overflow instead
  assign match_a  = advance && (count_r + 16'h0001 == cmp_a_r);
  assign match_p  = advance && (period_r != 16'h0000) && (count_r + 16'h0001 == period_r);
  // Overflow wraps to zero by itself; flagged only with period zero
  assign overflow = advance && (count_r == 16'hFFFF);
  assign ev_a     = match_a;
  assign ev_p     = !ctrl_b_r.cnt_clr_a && (match_p || (overflow && period_r == 16'h0000));
  // Clear source follows the clear-select bit
  assign clear_cnt = ctrl_b_r.cnt_clr_a ? match_a : (match_p || overflow);

  // On edge tracker
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_prev_r <= 1'b0;
    end else begin
      on_prev_r <= ctrl_a_r.on_off;
    end
  end

  // Off or paused leaves count untouched, so residue is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= RST_WORD;
    end else if (on_rise) begin
      count_r <= RST_WORD;
    end else if (clear_cnt) begin
      count_r <= RST_WORD;
    end else if (advance) begin
      count_r <= count_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare-match output pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_level_r <= 1'b0;
    end else if (ctrl_b_r.mode == PTCC_MD_CMP) begin
      if (on_rise) begin
        pin_level_r <= ctrl_b_r.out_ctl;
      end else if (ev_a) begin
        case (ctrl_b_r.out_sel)
          2'h1:    pin_level_r <= 1'b0;
          2'h2:    pin_level_r <= 1'b1;
          2'h3:    pin_level_r <= !pin_level_r;
          default: pin_level_r <= pin_level_r;
        endcase
      end
    end
  end

  // Pin level after polarity; held while the unit is off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_out_o <= 1'b0;
    end else begin
      timer_out_o <= pin_level_r ^ ctrl_b_r.polarity;
    end
  end

  // Pin driven only outside timer/counter mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_out_oe_o <= 1'b0;
    end else begin
      timer_out_oe_o <= (ctrl_b_r.mode != PTCC_MD_TMR);
    end
  end

  // Power gate follows the on/off bit, one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_enable_o <= 1'b0;
    end else begin
      unit_enable_o <= ctrl_a_r.on_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt flags; a new event wins over the read clear
  always_comb begin
    irq_nxt = rd_stat ? 2'h0 : irq_status_r;
    if (ev_a) begin
      irq_nxt[POS_IRQ_A] = 1'b1;
    end
    if (ev_p) begin
      irq_nxt[POS_IRQ_P] = 1'b1;
    end
  end

  // Status register takes the merged set and clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= RST_IRQ;
    end else begin
      irq_status_r <= irq_nxt;
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= RST_IRQ;
    end else if (wr_hit && req.adr == OFS_IRQ_MASK) begin
      irq_mask_r <= req.dat[1:0];
    end
  end

  // Level request from next status, so it drops with the clearing read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_nxt & irq_mask_r);
    end
  end

endmodule
`default_nettype wire

/* dv/ptcc_timer_assertions.sv */
// Checker for the timer control block, bound onto its top module.
// Assumes one clock domain and a one-cycle registered ack.
`timescale 1ns/100ps
`default_nettype none
module ptcc_timer_assertions
  import ptcc_pkg::*;
(
  // Clock, reset and bus
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // Status pins
  input  wire logic        timer_out_oe_o,
  input  wire logic        unit_enable_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////
  // Request seen by an idle slave
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Byte write taken at one offset
  sequence wr_s(logic [5:0] ofs);
    take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == ofs);
  endsequence
  ////////////////////////////////
  ack_answers_a: assert property (take_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  ctrl_low_zero_a: assert property ((take_s ##0 (!wb_we_i && wb_adr_i == OFS_CONTROL_A)) |=>
    wb_dat_o[2:0] == 3'h0) else $error("control bits 2..0 not zero");
  on_follows_a: assert property (wr_s(OFS_CONTROL_A) |->
    ##2 unit_enable_o == $past(wb_dat_i[POS_ON_OFF], 2)) else $error("unit enable wrong");
  oe_mode_a: assert property (wr_s(OFS_CONTROL_B) |->
    ##2 timer_out_oe_o == ($past(wb_dat_i[7:6], 2) != 2'h3)) else $error("output enable wrong");
  irq_drop_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2))
    else $error("irq fell without access");
endmodule
bind ptcc_timer ptcc_timer_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
  .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_out_oe_o, .unit_enable_o, .irq_o);
`default_nettype wire

/* dv/ptcc_pin_model.sv */
// Far-side pins: external clock source and timer output load.
// Assumes the bench calls pulse() right after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module ptcc_pin_model (
  // Clock
  input  wire logic clk_i,
  // Timer output pin
  input  wire logic timer_out_i,
  input  wire logic timer_out_oe_i,
  output logic      pin_level_o,
  // External clock pin
  output logic      ext_clk_o
);
  // Pull-down holds the net when undriven
  assign pin_level_o = timer_out_oe_i ? timer_out_i : 1'b0;
  // Pin stands low outside bursts
  initial ext_clk_o = 1'b0;
  // Hold sets speed; slow edges keep the synchroniser honest
  task automatic pulse(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk_i);
      ext_clk_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      ext_clk_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* dv/ptcc_timer_bench.sv */
// Directed bench for the timer control block.
// Assumes the pin model on the far side and a 50 ns clock.
`timescale 1ns/100ps
`default_nettype none
module ptcc_timer_bench;
  import ptcc_pkg::*;
  // Stimulus and observed signals
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  ptcc_wb_req_type req = '0;
  logic            hi_tick = 1'b0;
  logic            sub_tick = 1'b0;
  logic [31:0]     rdat;
  logic            ack, pin_out, pin_oe, unit_en, irq, ext_pin, pin_lvl;
  logic [7:0]      lo, hi, v;
  logic [15:0]     e;
  int              mismatches = 0;
  int              checked = 0;
  int              cyc_n = 0;
  int              take_t, t0;
  // Clock and cycle count
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;
  ptcc_timer DUT (.clk_i, .rst_i, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .high_tick_i(hi_tick), .sub_tick_i(sub_tick), .ext_clk_pin_i(ext_pin),
    .timer_out_o(pin_out), .timer_out_oe_o(pin_oe), .unit_enable_o(unit_en), .irq_o(irq));
  ptcc_pin_model pins (.clk_i, .timer_out_i(pin_out), .timer_out_oe_i(pin_oe),
    .pin_level_o(pin_lvl), .ext_clk_o(ext_pin));
  ////////////////////////////////
  // One classic cycle, then one idle cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    req <= '{1'b1, 1'b1, w, 4'h1, a, {24'h000000, d}};
    // No cycle count assumed: only the watchdog ends a wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    take_t = cyc_n - 1;
    q = rdat[7:0];
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
    checked++;
    if (g !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task automatic chk1(input string nm, input logic ex, input logic g);
    checked++;
    if (g !== ex) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, ex, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00, v);
    chk(nm, {8'h00, ex}, {8'h00, v});
  endtask
  // Count through both byte registers
  task automatic cnt(input logic [15:0] ex);
    bus(1'b0, OFS_COUNT_LOW, 8'h00, lo);
    bus(1'b0, OFS_COUNT_HIGH, 8'h00, hi);
    chk("count", ex, {hi, lo});
  endtask
  // Single-cycle enable pulses on high clock or subclock
  task automatic ticks(input bit sub, input int n);
    repeat (n) begin
      if (sub) sub_tick <= 1'b1;
      else hi_tick <= 1'b1;
      @(posedge clk_i);
      sub_tick <= 1'b0;
      hi_tick <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // Off, then on while paused: count cleared and frozen
  task automatic restart(input logic [2:0] s);
    wr(OFS_CONTROL_A, {1'b1, s, 4'h0});
    wr(OFS_CONTROL_A, {1'b1, s, 4'h8});
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////
  // Watchdog, far beyond the roughly one thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 10; a++) rdc("reset", 6'(a * 4), 8'h00);
    rdc("unmapped", 6'h3C, 8'h00);
    $display("test reset done");
    for (int a = 4; a < 8; a++) begin
      wr(6'(a * 4), 8'(8'hA0 + a));
      rdc("compare", 6'(a * 4), 8'(8'hA0 + a));
    end
    wr(OFS_COUNT_LOW, 8'h5A);
    cnt(16'h0000);
    wr(OFS_CONTROL_A, 8'hFF);
    rdc("ctrl_a", OFS_CONTROL_A, 8'hF8);
    wr(OFS_CONTROL_B, 8'h5A);
    rdc("ctrl_b", OFS_CONTROL_B, 8'h5A);
    wr(OFS_CONTROL_B, 8'hC0);
    wr(OFS_PERIOD_LOW, 8'h00);
    wr(OFS_PERIOD_HIGH, 8'h00);
    $display("test registers done");
    // Every clock source, counted in a window from a cleared count
    for (int s = 0; s < 8; s++) begin
      restart(3'(s));
      wr(OFS_CONTROL_A, {1'b0, 3'(s), 4'h8});
      t0 = take_t;
      case (s)
        2: ticks(1'b0, 32);
        3: ticks(1'b0, 64);
        4, 5: ticks(1'b1, 4);
        6, 7: pins.pulse(s + 3, 4);
        default: repeat (35) @(posedge clk_i);
      endcase
      repeat (6) @(posedge clk_i);
      wr(OFS_CONTROL_A, {1'b1, 3'(s), 4'h8});
      case (s)
        0: e = 16'((take_t - t0) / 4);
        1: e = 16'(take_t - t0);
        2: e = 16'h0002;
        3: e = 16'h0001;
        4, 5: e = 16'h0004;
        default: e = 16'(s + 3);
      endcase
      cnt(e);
    end
    $display("test sources done");
    restart(3'h1);
    wr(OFS_CONTROL_A, 8'h18);
    t0 = take_t;
    wr(OFS_CONTROL_A, 8'h98);
    e = 16'(take_t - t0);
    cnt(e);
    cnt(e);
    wr(OFS_CONTROL_A, 8'h18);
    t0 = take_t;
    wr(OFS_CONTROL_A, 8'h10);
    e = e + 16'(take_t - t0);
    chk1("unit_en", 1'b0, unit_en);
    cnt(e);
    cnt(e);
    wr(OFS_CONTROL_A, 8'h98);
    cnt(16'h0000);
    $display("test pause done");
    // Period clears, compare A needs its high byte too
    wr(OFS_CMP_A_LOW, 8'h03);
    wr(OFS_CMP_A_HIGH, 8'h01);
    wr(OFS_PERIOD_LOW, 8'h05);
    wr(OFS_IRQ_MASK, 8'h03);
    wr(OFS_CONTROL_B, 8'h38);
    restart(3'h4);
    wr(OFS_CONTROL_A, 8'h48);
    ticks(1'b1, 7);
    wr(OFS_CONTROL_A, 8'hC8);
    cnt(16'h0002);
    chk1("irq", 1'b1, irq);
    chk1("pin", 1'b1, pin_lvl);
    rdc("status", OFS_IRQ_STATUS, 8'h02);
    chk1("irq", 1'b0, irq);
    // Compare A clears when selected; masked flag keeps irq low
    wr(OFS_CMP_A_HIGH, 8'h00);
    wr(OFS_IRQ_MASK, 8'h00);
    wr(OFS_CONTROL_B, 8'h39);
    restart(3'h4);
    wr(OFS_CONTROL_A, 8'h48);
    ticks(1'b1, 5);
    wr(OFS_CONTROL_A, 8'hC8);
    cnt(16'h0002);
    chk1("irq", 1'b0, irq);
    chk1("pin", 1'b0, pin_lvl);
    rdc("status", OFS_IRQ_STATUS, 8'h01);
    restart(3'h4);
    repeat (2) @(posedge clk_i);
    chk1("pin", 1'b1, pin_lvl);
    // Set-high action with inverted polarity, cleared by compare A
    wr(OFS_CONTROL_B, 8'h25);
    restart(3'h4);
    repeat (2) @(posedge clk_i);
    chk1("pin_pol", 1'b1, pin_lvl);
    wr(OFS_CONTROL_A, 8'h48);
    ticks(1'b1, 3);
    repeat (2) @(posedge clk_i);
    chk1("pin_pol", 1'b0, pin_lvl);
    $display("test match done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
